// File: verilog/warn_pkg.sv
// shared constants and carrier types for the warning encoder
`default_nettype none
package warn_pkg;
	// ----------------------------------------------------------------
	// action code field
	// ----------------------------------------------------------------
	localparam int CODE_W = 4;               // action code width
	localparam int SENSOR_W = 32;            // sensor word width
	localparam logic [3:0] CODE_NONE = 4'h0;     // nothing pending
	localparam logic [3:0] CODE_COOLING = 4'h1;  // cooling warning
	localparam logic [3:0] CODE_POWER = 4'h2;    // power warning
	localparam logic [3:0] CODE_SHUTDOWN = 4'h3; // orderly shutdown
	localparam logic [3:0] CODE_HALT = 4'h4;     // quick halt
	localparam logic [3:0] CODE_MAYLOSE = 4'h5;  // possible power loss
	localparam logic [3:0] CODE_WILLLOSE = 4'h7; // certain power loss
	localparam int CODE_LSB = 0;             // field position in sensor
	localparam logic [7:0] SUPPORT_ALL = 8'hbf;  // codes 0-5 and 7

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 10000;          // 10 MHz system clock
	localparam int HOLD_TIME_MS = 4;         // least power left after loss
	localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ; // rounds exact
	localparam int CNT_W = 16;               // hold counter width
	localparam int NUM_WARN = 6;             // warning inputs

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic certainLoss;   // supply will drop
		logic possibleLoss;  // supply may drop
		logic halt;          // quick halt needed
		logic shutdown;      // orderly shutdown needed
		logic power;         // non-critical power problem
		logic cooling;       // non-critical cooling problem
	} warn_t;

	typedef struct packed {
		logic [SENSOR_W-CODE_W-1:0] zero; // always reads zero
		logic [CODE_W-1:0]          code; // current action code
	} sensor_t;

	localparam warn_t WARN_NONE = '0;     // idle warning set
	localparam sensor_t SENSOR_RST = '0;  // sensor after reset
endpackage : warn_pkg
`default_nettype wire

// File: verilog/sync_bits.sv
// two-stage synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
	parameter int W = 1                    // number of bits
) (
	input  wire logic         clk,         // system clock
	input  wire logic         rstn,        // synced reset, active low
	input  wire logic         ce,          // clock enable
	input  wire logic [W-1:0] din,         // asynchronous inputs
	output logic      [W-1:0] dout         // synchronised outputs
);
	// ----------------------------------------------------------------
	// per-bit double flop
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;   // first stage, read by stage two and by its own hold mux
			logic stab_q;   // second stage
			logic meta_d;   // next first stage
			logic stab_d;   // next second stage
			// freeze both stages while ce is low
			always_comb begin
				meta_d = ce ? din[i] : meta_q;
				stab_d = ce ? meta_q : stab_q;
			end
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= meta_d;
					stab_q <= stab_d;
				end
			end
			assign dout[i] = stab_q;
		end
	endgenerate
endmodule : sync_bits
`default_nettype wire

// File: verilog/action_encoder.sv
// priority encoder from warning set to action code
`timescale 1ns/1ps
`default_nettype none
module action_encoder
	import warn_pkg::*;
#(
	parameter logic [7:0] SUPPORTED = SUPPORT_ALL // implemented codes
) (
	input  wire warn_t             warn,  // pending conditions
	input  wire logic              lossHeld, // latched possible loss
	output logic      [CODE_W-1:0] code   // highest supported code
);
	// ----------------------------------------------------------------
	// highest first, unsupported codes simply never win
	// ----------------------------------------------------------------
	always_comb begin
		code = CODE_NONE;                                  // R19
		if (warn.certainLoss && SUPPORTED[7]) begin
			code = CODE_WILLLOSE;                          // R6
		end else if ((warn.possibleLoss || lossHeld) && SUPPORTED[5]) begin
			code = CODE_MAYLOSE;                           // R8
		end else if (warn.halt && SUPPORTED[4]) begin
			code = CODE_HALT;                              // R3
		end else if (warn.shutdown && SUPPORTED[3]) begin
			code = CODE_SHUTDOWN;                          // R5
		end else if (warn.power && SUPPORTED[2]) begin
			code = CODE_POWER;                             // R5
		end else if (warn.cooling && SUPPORTED[1]) begin
			code = CODE_COOLING;                           // R4
		end
	end
endmodule : action_encoder
`default_nettype wire

// File: verilog/power_environment_warning_encoder.sv
// warning encoder top: sensor value, warning interrupt, supply hold
// What the document requires of this block and of software
// (R1) provide a sensor readable by runtime firmware
// (R2) action code sits in low four bits
// (R3) present the highest pending action code
// (R4) subset allowed; supported codes behave exactly
// (R5) codes: 0 none,1 cool,2 power,3 shutdown,4 halt
// (R6) possible loss is 5, certain loss 7
// (R7) keep power four milliseconds after loss warning
// (R8) hold code 5 until power is safe
// (R9) signal power loss codes by interrupt
// (R10) never lose interrupt to a later higher event
// (R11) defer new interrupt until current one reset
// (R12) ignore resets until all events are reported
// (R13) software enables interrupt and reads sensor
// (R14) software masks and polls on code 5
// (R15) software re-reads every 50 ms, resumes
// (R16) software leaves code 7 interrupt uncleared
// (R17) software schedules shutdown for codes 3, 4
// (R18) never present 6, above 7, or upper bits
// (R19) no warning means code 0, interrupt low
`timescale 1ns/1ps
`default_nettype none
module power_environment_warning_encoder
	import warn_pkg::*;
#(
	parameter logic [7:0] SUPPORTED = SUPPORT_ALL, // implemented codes
	parameter int         HOLD_CYC  = HOLD_CYCLES  // supply hold cycles
) (
	input  wire logic    clk,          // 10 MHz system clock
	input  wire logic    rstn,         // async reset, active low
	input  wire logic    ce,           // clock enable, freezes state
	input  wire warn_t   warnPins,     // monitor pins, asynchronous
	input  wire logic    powerSafe,    // supply in safe range, async
	input  wire logic    sensorRead,   // firmware sensor read pulse
	input  wire logic    intReset,     // firmware interrupt reset pulse
	input  wire logic    intMask,      // interrupt mask level
	output sensor_t      sensor_q,     // sensor value
	output logic         warnIrq_q,    // warning interrupt, high active
	output logic         supplyHold_q  // keep supply up, high active
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rstnMeta_q;   // first reset stage
	logic rstnSync_q;   // released reset used everywhere else

	// release through two flops so every flop leaves reset together
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstnMeta_q <= 1'b0;
			rstnSync_q <= 1'b0;
		end else begin
			rstnMeta_q <= 1'b1;
			rstnSync_q <= rstnMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	warn_t warnSync;    // synchronised warning set
	logic  safeSync;    // synchronised safe-power level

	sync_bits #(
		.W    (NUM_WARN + 1)
	) u_sync (
		.clk  (clk),
		.rstn (rstnSync_q),
		.ce   (ce),
		.din  ({powerSafe, warnPins}),
		.dout ({safeSync, warnSync})
	);

	// ----------------------------------------------------------------
	// code selection and possible-loss latch
	// ----------------------------------------------------------------
	logic              lossHeld_q;  // possible loss seen, not yet safe
	logic              lossHeld_d;  // next latch value
	logic [CODE_W-1:0] codeNext;    // encoder output
	sensor_t           sensor_d;    // next sensor value

	action_encoder #(
		.SUPPORTED (SUPPORTED)
	) u_enc (
		.warn      (warnSync),
		.lossHeld  (lossHeld_q),
		.code      (codeNext)
	);

	// the latch lets a brief dip keep code 5 up until power is safe
	always_comb begin
		lossHeld_d = lossHeld_q;
		sensor_d   = sensor_q;
		if (ce) begin
			if (warnSync.possibleLoss && SUPPORTED[5]) begin
				lossHeld_d = 1'b1;                         // R8
			end else if (safeSync) begin
				lossHeld_d = 1'b0;                         // R8
			end
			sensor_d.zero = '0;                            // R18
			sensor_d.code = codeNext;                      // R2
		end
	end

	always_ff @(posedge clk or negedge rstnSync_q) begin
		if (!rstnSync_q) begin
			lossHeld_q <= 1'b0;
			sensor_q   <= SENSOR_RST;
		end else begin
			lossHeld_q <= lossHeld_d;
			sensor_q   <= sensor_d;                        // R1
		end
	end

	// ----------------------------------------------------------------
	// interrupt tracking
	// ----------------------------------------------------------------
	typedef enum logic {
		IRQ_IDLE = 1'b0,    // nothing unreported
		IRQ_PEND = 1'b1     // interrupt raised, awaiting reset
	} irq_state_t;

	irq_state_t        irq_q;       // interrupt state
	irq_state_t        irq_d;       // next interrupt state
	logic [CODE_W-1:0] readCode_q;  // code firmware last read
	logic [CODE_W-1:0] readCode_d;  // next read snapshot
	logic [CODE_W-1:0] acked_q;     // code already answered
	logic [CODE_W-1:0] acked_d;     // next answered code
	logic              warnIrq_d;   // next interrupt pin
	logic [CODE_W-1:0] curCode;     // code now presented

	assign curCode = sensor_q.code;

	// a reset is refused while the code is above the snapshot, so an
	// event landing between read and reset still keeps the line up
	always_comb begin
		irq_d      = irq_q;
		readCode_d = readCode_q;
		acked_d    = acked_q;
		warnIrq_d  = warnIrq_q;
		if (ce) begin
			if (sensorRead) begin
				readCode_d = curCode;                      // R10
			end
			if (curCode == CODE_NONE) begin
				irq_d   = IRQ_IDLE;                        // R19
				acked_d = CODE_NONE;
			end else begin
				// falling codes re-arm so a later rise interrupts again
				if (curCode < acked_q) begin
					acked_d = curCode;
				end
				unique case (irq_q)
					IRQ_IDLE: begin
						if (curCode > acked_q) begin
							irq_d = IRQ_PEND;              // R9
						end
					end
					IRQ_PEND: begin
						// no new raise while pending: one line only
						if (intReset && curCode <= readCode_q) begin
							irq_d   = IRQ_IDLE;            // R11
							acked_d = readCode_q;
						end                                // R12
					end
				endcase
			end
			warnIrq_d = (irq_d == IRQ_PEND) && !intMask;   // R9
		end
	end

	always_ff @(posedge clk or negedge rstnSync_q) begin
		if (!rstnSync_q) begin
			irq_q      <= IRQ_IDLE;
			readCode_q <= CODE_NONE;
			acked_q    <= CODE_NONE;
			warnIrq_q  <= 1'b0;
		end else begin
			irq_q      <= irq_d;
			readCode_q <= readCode_d;
			acked_q    <= acked_d;
			warnIrq_q  <= warnIrq_d;
		end
	end

	// ----------------------------------------------------------------
	// supply hold after a loss warning
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HOLD_IDLE = 2'b00,  // no loss warning
		HOLD_RUN  = 2'b01,  // holding supply up
		HOLD_DONE = 2'b10   // hold served, waiting for recovery
	} hold_state_t;

	hold_state_t      hold_q;     // hold state
	hold_state_t      hold_d;     // next hold state
	logic [CNT_W-1:0] holdCnt_q;  // cycles held so far
	logic [CNT_W-1:0] holdCnt_d;  // next count
	logic             supplyHold_d; // next hold output
	logic             lossCode;   // code 5 or 7 presented

	assign lossCode = (curCode == CODE_MAYLOSE) ||
		(curCode == CODE_WILLLOSE);

	// hardware, not software, guards the 4 ms window
	always_comb begin
		hold_d       = hold_q;
		holdCnt_d    = holdCnt_q;
		supplyHold_d = supplyHold_q;
		if (ce) begin
			unique case (hold_q)
				HOLD_IDLE: begin
					holdCnt_d = '0;
					if (lossCode) begin
						hold_d = HOLD_RUN;                 // R7
					end
				end
				HOLD_RUN: begin
					if (holdCnt_q == CNT_W'(HOLD_CYC - 1)) begin
						hold_d = HOLD_DONE;                // R7
					end else begin
						holdCnt_d = holdCnt_q + 1'b1;
					end
				end
				HOLD_DONE: begin
					if (!lossCode) begin
						hold_d = HOLD_IDLE;
					end
				end
				default: begin
					hold_d = HOLD_IDLE;
				end
			endcase
			supplyHold_d = (hold_d == HOLD_RUN);
		end
	end

	always_ff @(posedge clk or negedge rstnSync_q) begin
		if (!rstnSync_q) begin
			hold_q       <= HOLD_IDLE;
			holdCnt_q    <= '0;
			supplyHold_q <= 1'b0;
		end else begin
			hold_q       <= hold_d;
			holdCnt_q    <= holdCnt_d;
			supplyHold_q <= supplyHold_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstnSync_q || !ce);

	sequence s_readLow;
		sensorRead ##1 (curCode > readCode_q);
	endsequence
	sequence s_resetTry;
		intReset && irq_q == IRQ_PEND;
	endsequence

	a_code_legal: assert property ( // R18
		curCode != 4'h6 && curCode <= CODE_WILLLOSE)
		else $error("illegal action code presented");
	a_upper_zero: assert property ( // R2
		sensor_q.zero == '0)
		else $error("sensor upper bits not zero");
	a_certain_top: assert property ( // R3
		(warnSync.certainLoss && SUPPORTED[7] && ce) |=>
		curCode == CODE_WILLLOSE)
		else $error("certain loss not presented as top code");
	a_loss_sticky: assert property ( // R8
		(curCode == CODE_MAYLOSE && !safeSync && ce) |=>
		curCode >= CODE_MAYLOSE)
		else $error("possible loss code dropped early");
	a_idle_quiet: assert property ( // R19
		(curCode == CODE_NONE) ##1 (curCode == CODE_NONE) |=>
		!warnIrq_q)
		else $error("interrupt up with no warning");
	a_raise_irq: assert property ( // R9
		(irq_q == IRQ_IDLE && curCode > acked_q) |=> irq_q == IRQ_PEND)
		else $error("new higher code did not interrupt");
	a_no_lost: assert property ( // R10
		s_readLow ##0 s_resetTry |=> irq_q == IRQ_PEND)
		else $error("interrupt lost to later higher event");
	a_mask_gate: assert property ( // R9
		intMask |=> !warnIrq_q)
		else $error("masked interrupt reached pin");
	a_hold_span: assert property ( // R7
		$fell(supplyHold_q) |-> $past(holdCnt_q) == CNT_W'(HOLD_CYC - 1))
		else $error("supply hold ended before window");
	a_hold_start: assert property ( // R7
		(hold_q == HOLD_IDLE && lossCode) |=> supplyHold_q)
		else $error("supply hold did not start on loss");
endmodule : power_environment_warning_encoder
`default_nettype wire

// File: tb/warn_fw_model.sv
// behavioural firmware model that reads the sensor and resets the irq
`timescale 1ns/1ps
`default_nettype none
module warn_fw_model
	import warn_pkg::*;
(
	input  wire logic    clk,      // system clock
	input  wire logic    rstn,     // reset, active low
	input  wire logic    en,       // model answers interrupts
	input  wire sensor_t sensor,   // sensor word from the device
	input  wire logic    irq,      // warning interrupt
	output logic         fwRead,   // sensor read pulse
	output logic         fwReset,  // interrupt reset pulse
	output logic         fwMask,   // interrupt mask level
	output logic [3:0]   lastCode, // code seen by the last read
	output logic         schedDown // shutdown scheduled by the handler
);
	// ----------------------------------------------------------------
	// handler sequence
	// ----------------------------------------------------------------
	logic [1:0] st;   // 0 idle, 1 reading, 2 resetting, 3 settle
	logic [3:0] cnt;  // settle cycles
	// signals change only on the edge, so the device sees whole pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= 2'h0;
			cnt <= 4'h0;
			fwRead <= 1'b0;
			fwReset <= 1'b0;
			fwMask <= 1'b0;
			lastCode <= 4'h0;
			schedDown <= 1'b0;
		end else begin
			fwRead <= 1'b0;
			fwReset <= 1'b0;
			case (st)
				2'h0: begin
					// unmask once the possible loss has gone
					if (fwMask && sensor.code != CODE_MAYLOSE)
						fwMask <= 1'b0;
					if (en && irq) begin
						fwRead <= 1'b1;
						st <= 2'h1;
					end
				end
				2'h1: begin
					lastCode <= sensor.code;
					// shutdown or quick halt: log and plan the power-down
					if (sensor.code == CODE_SHUTDOWN ||
						sensor.code == CODE_HALT) begin
						schedDown <= 1'b1;
					end
					cnt <= 4'h0;
					// certain loss: leave the interrupt standing
					if (sensor.code == CODE_WILLLOSE) begin
						st <= 2'h3;
					end else begin
						fwReset <= 1'b1;
						fwMask <= (sensor.code == CODE_MAYLOSE);
						st <= 2'h2;
					end
				end
				2'h2: st <= 2'h3;
				default: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'h7 && lastCode != CODE_WILLLOSE)
						st <= 2'h0;
				end
			endcase
		end
	end
endmodule : warn_fw_model
`default_nettype wire

// File: tb/power_environment_warning_encoder_tb_top.sv
// self-checking bench for the warning encoder
`timescale 1ns/1ps
`default_nettype none
module power_environment_warning_encoder_tb_top
	import warn_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int HOLD = 20;                  // shortened supply hold
	localparam logic [3:0] EXP [0:5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
	logic       clk = 1'b0;                    // system clock
	logic       rstn = 1'b0;                   // reset, active low
	logic       ce = 1'b1;                     // clock enable
	warn_t      pins = '0;                     // monitor pins
	logic       powerSafe = 1'b1;              // supply safe
	logic       tbRead = 1'b0;                 // bench read pulse
	logic       tbReset = 1'b0;                // bench reset pulse
	logic       tbMask = 1'b0;                 // bench mask
	logic       fwEn = 1'b0;                   // hand control to model
	logic       fwRead, fwReset, fwMask;       // model outputs
	logic [3:0] lastCode;                      // code model saw
	logic       schedDown;                     // model planned shutdown
	logic       rd, rs, mk;                    // muxed firmware inputs
	sensor_t    sensor;                        // sensor word
	logic       irq, hold;                     // irq and supply hold
	int         failCount = 0;                 // mismatches
	int         nChecks = 0;                   // comparisons
	int         cyc = 0;                       // timeout counter
	int         n;                             // scratch count
	assign rd = fwEn ? fwRead : tbRead;
	assign rs = fwEn ? fwReset : tbReset;
	assign mk = fwEn ? fwMask : tbMask;

`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin failCount++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

	always #50 clk = ~clk;

	power_environment_warning_encoder #(.HOLD_CYC(HOLD)) u_dut (
		.clk(clk), .rstn(rstn), .ce(ce), .warnPins(pins),
		.powerSafe(powerSafe), .sensorRead(rd), .intReset(rs),
		.intMask(mk), .sensor_q(sensor), .warnIrq_q(irq),
		.supplyHold_q(hold));

	warn_fw_model u_fw (
		.clk(clk), .rstn(rstn), .en(fwEn), .sensor(sensor), .irq(irq),
		.fwRead(fwRead), .fwReset(fwReset), .fwMask(fwMask),
		.lastCode(lastCode), .schedDown(schedDown));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// every step ends just after an edge, so inputs and samples agree
	task automatic wc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : wc
	task automatic ack();
		tbRead = 1'b1;
		wc(1);
		tbRead = 1'b0;
		tbReset = 1'b1;
		wc(1);
		tbReset = 1'b0;
		wc(2);
	endtask : ack
	task automatic conclude();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_idle();
		`CHK("code", CODE_NONE, sensor.code)
		`CHK("irq", 1'b0, irq)
		ce = 1'b0;                             // frozen: pin ignored
		pins.cooling = 1'b1;
		wc(6);
		`CHK("code", CODE_NONE, sensor.code)
		ce = 1'b1;
		wc(6);
		`CHK("code", CODE_COOLING, sensor.code)
		ack();
		pins = '0;
		wc(6);
		$display("test idle done");
	endtask : t_idle
	task automatic t_codes();
		for (int i = 0; i < 6; i++) begin
			pins = warn_t'(6'h01 << i);
			wc(6);
			`CHK("code", EXP[i], sensor.code)
			`CHK("zero", 28'h0, sensor.zero)
			`CHK("irq", 1'b1, irq)
			ack();
			`CHK("irq", 1'b0, irq)
			pins = '0;
			wc(HOLD + 8);
			`CHK("code", CODE_NONE, sensor.code)
		end
		$display("test codes done");
	endtask : t_codes
	task automatic t_hold();
		pins.certainLoss = 1'b1;
		n = 0;
		while (hold !== 1'b1 && n < 8) begin
			wc(1);
			n++;
		end
		n = 0;
		while (hold === 1'b1 && n < 3 * HOLD) begin
			wc(1);
			n++;
		end
		`CHK("hold", HOLD, n)
		wc(4);
		`CHK("rearm", 1'b0, hold)
		ack();
		pins = '0;
		wc(6);
		$display("test hold done");
	endtask : t_hold
	task automatic t_prio();
		pins = warn_t'(6'h3f);
		wc(6);
		`CHK("code", CODE_WILLLOSE, sensor.code)
		pins = warn_t'(6'h1f);
		wc(6);
		`CHK("code", CODE_MAYLOSE, sensor.code)
		pins = warn_t'(6'h0f);
		wc(6);
		`CHK("code", CODE_HALT, sensor.code)
		pins = warn_t'(6'h03);
		wc(6);
		`CHK("code", CODE_POWER, sensor.code)
		ack();
		pins = '0;
		wc(6);
		`CHK("irq", 1'b0, irq)
		$display("test priority done");
	endtask : t_prio
	task automatic t_latch();
		powerSafe = 1'b0;
		pins.possibleLoss = 1'b1;
		wc(6);
		pins = '0;
		wc(30);
		`CHK("code", CODE_MAYLOSE, sensor.code)
		ack();
		powerSafe = 1'b1;
		wc(6);
		`CHK("code", CODE_NONE, sensor.code)
		$display("test latch done");
	endtask : t_latch
	task automatic t_race();
		pins.power = 1'b1;
		wc(6);
		pins.possibleLoss = 1'b1;
		wc(2);
		tbRead = 1'b1;                         // snapshot holds code 2
		wc(1);
		tbRead = 1'b0;                         // code 5 lands at this edge
		tbReset = 1'b1;                        // must be refused
		wc(1);
		tbReset = 1'b0;
		wc(2);
		`CHK("irq", 1'b1, irq)
		ack();
		`CHK("irq", 1'b0, irq)
		pins = '0;
		wc(HOLD + 8);
		$display("test race done");
	endtask : t_race
	task automatic t_mask();
		pins.shutdown = 1'b1;
		wc(6);
		tbMask = 1'b1;
		wc(2);
		`CHK("irq", 1'b0, irq)
		tbMask = 1'b0;
		wc(2);
		`CHK("irq", 1'b1, irq)
		ack();
		pins = '0;
		wc(6);
		$display("test mask done");
	endtask : t_mask
	task automatic t_fw();
		fwEn = 1'b1;
		pins.cooling = 1'b1;
		wc(16);
		`CHK("irq", 1'b0, irq)
		`CHK("seen", CODE_COOLING, lastCode)
		`CHK("sched", 1'b0, schedDown)
		pins = '0;
		wc(16);
		pins.shutdown = 1'b1;
		wc(16);
		`CHK("sched", 1'b1, schedDown)
		`CHK("irq", 1'b0, irq)
		pins = '0;
		wc(16);
		pins.possibleLoss = 1'b1;
		wc(12);
		`CHK("mask", 1'b1, mk)
		pins = '0;
		wc(16);
		`CHK("mask", 1'b0, mk)
		pins.certainLoss = 1'b1;
		wc(24);
		`CHK("irq", 1'b1, irq)
		`CHK("seen", CODE_WILLLOSE, lastCode)
		pins = '0;
		wc(8);
		`CHK("code", CODE_NONE, sensor.code)
		fwEn = 1'b0;
		$display("test firmware done");
	endtask : t_fw

	// ----------------------------------------------------------------
	// main sequence and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			failCount++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rstn = 1'b1;
		wc(4);
		t_idle();
		t_hold();
		t_codes();
		t_prio();
		t_latch();
		t_race();
		t_mask();
		t_fw();
		conclude();
	end
endmodule : power_environment_warning_encoder_tb_top
`default_nettype wire
